//--- verilog/standby_irq_defs.svh
// Purpose: Offsets-free timing constants for the standby and IRQ block
// Assumes: 100 MHz clock
// Notes:   Times kept in their own unit, cycle counts derived from them
`ifndef STANDBY_IRQ_DEFS_SVH
`define STANDBY_IRQ_DEFS_SVH

`define SIC_CLK_PERIOD_NS   10
// Power-on hold of host and bus-interface resets
`define SIC_POR_HOLD_MS     300
`define SIC_POR_HOLD_CYC    ((`SIC_POR_HOLD_MS * 1000000) / `SIC_CLK_PERIOD_NS)
// Key debounce window, least time, rounded up
`define SIC_DEBOUNCE_US     2000
`define SIC_DEBOUNCE_CYC    \
   (((`SIC_DEBOUNCE_US * 1000) + `SIC_CLK_PERIOD_NS - 1) / `SIC_CLK_PERIOD_NS)
// Rail restoration delay before interrupts are enabled
`define SIC_RESTORE_MS      20
`define SIC_RESTORE_CYC     ((`SIC_RESTORE_MS * 1000000) / `SIC_CLK_PERIOD_NS)
// Idle level of the key input and reset value of the host interrupt output
`define SIC_IDLE_HIGH       1'b1

`endif

//--- verilog/standby_irq_pkg.sv
// Purpose: Types shared by the standby and IRQ block
// Assumes: Nothing
// Notes:   One-hot state codes written out
`default_nettype none
package standby_irq_pkg;
   typedef enum logic [1:0] {
      PWR_OPERATE = 2'b01,
      PWR_STANDBY = 2'b10
   } pwr_state_t;
endpackage
`default_nettype wire

//--- verilog/key_debounce.sv
// Purpose: Debounce a level input and mark its edges
// Assumes: Input synchronous to clk
// Notes:   Edge pulses last one cycle
`timescale 1ns/10ps
`default_nettype none
module key_debounce #(
   parameter int unsigned STABLE_CYC = 200000,
   parameter logic        IDLE       = 1'b1
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic raw,
   output var  logic level_r,
   output var  logic fall_r,
   output var  logic rise_r
);
   logic [31:0] cnt_r;

   if (STABLE_CYC < 1) begin : g_bad_cyc
      $error("key_debounce: STABLE_CYC must be at least 1");
   end

   // Level only follows after raw has held steady for the whole window
   always_ff @(posedge clk) begin
      if (rst || raw == level_r) begin
         cnt_r <= 32'h0000_0000;
      end else if (cnt_r == STABLE_CYC - 1) begin
         cnt_r <= 32'h0000_0000;
      end else begin
         cnt_r <= cnt_r + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         level_r <= IDLE;
         fall_r  <= 1'b0;
         rise_r  <= 1'b0;
      end else begin
         fall_r <= 1'b0;
         rise_r <= 1'b0;
         if (raw != level_r && cnt_r == STABLE_CYC - 1) begin
            level_r <= raw;
            fall_r  <= ~raw;
            rise_r  <= raw;
         end
      end
   end
endmodule // key_debounce
`default_nettype wire

//--- verilog/hold_timer.sv
// Purpose: Count cycles while run is high, then flag done
// Assumes: Single clock
// Notes:   Dropping run restarts the count
`timescale 1ns/10ps
`default_nettype none
module hold_timer #(
   parameter int unsigned CYCLES = 1000
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic run,
   output var  logic done_r
);
   logic [31:0] cnt_r;

   if (CYCLES < 1) begin : g_bad_cyc
      $error("hold_timer: CYCLES must be at least 1");
   end

   always_ff @(posedge clk) begin
      if (rst || !run) begin
         cnt_r  <= 32'h0000_0000;
         done_r <= 1'b0;
      end else if (cnt_r == CYCLES - 1) begin
         done_r <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 32'h0000_0001;
      end
   end
endmodule // hold_timer
`default_nettype wire

//--- verilog/standby_irq_combiner.sv
// Purpose: Standby control and interrupt combining for the host
// Assumes: All inputs synchronous to CLK; RST is the power-on reset
// Notes:   Host clears latches with one-cycle high pulses
//
// What this block does
// - Debounced standby key leading edge sets the standby interrupt latch.
// - Standby interrupt latch set drives host interrupt low.
// - Standby latch shows as an active-high readable flag.
// - Flag rising edge sets the standby state on entry.
// - In standby the indicator is lit and other interrupts blocked.
// - In standby the shutdown output switches off all but standby rail.
// - Key press in standby sets latch again; flag edge leaves standby.
// - Falling standby trigger from battery pack requests standby.
// - Once in standby only the key brings the unit back.
// - Keyboard ready rising edge sets the keyboard latch and flag.
// - Keyboard, measurement and bus interface interrupts are ORed.
// - Combined interrupt reaches host only outside standby.
// - Standby interrupt reaches host regardless of standby gating.
// - Main rail off masks host interrupt, holds bus-interface reset.
// - After rail returns, wait a delay before enabling interrupts.
// - Bus-interface reset released together with interrupt enable.
// - After power-on, host and bus resets held about 300 ms.
`timescale 1ns/10ps
`default_nettype none
`include "standby_irq_defs.svh"
module standby_irq_combiner #(
   parameter int unsigned POR_CYC      = `SIC_POR_HOLD_CYC,
   parameter int unsigned DEBOUNCE_CYC = `SIC_DEBOUNCE_CYC,
   parameter int unsigned RESTORE_CYC  = `SIC_RESTORE_CYC
) (
   input  wire logic CLK,
   input  wire logic RST,
   input  wire logic STANDBY_KEY_N,
   input  wire logic STANDBY_TRIG_N,
   input  wire logic KBD_READY,
   input  wire logic MEASUREMENT_IRQ,
   input  wire logic BUS_INTERFACE_IRQ,
   input  wire logic MAIN_RAIL_OK,
   input  wire logic STBY_LATCH_CLR,
   input  wire logic KBD_LATCH_CLR,
   output var  logic HOST_IRQ_N,
   output var  logic STBY_IRQ_FLAG,
   output var  logic KBD_IRQ_FLAG,
   output var  logic STANDBY_LED,
   output var  logic SHUTDOWN,
   output var  logic HOST_RESET_N,
   output var  logic BUS_IF_RESET_N
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   standby_irq_pkg::pwr_state_t state_r;
   standby_irq_pkg::pwr_state_t state_nxt;
   logic key_fall;
   logic trig_d_r;
   logic trig_fall;
   logic kbd_d_r;
   logic kbd_rise;
   logic stby_irq_r;
   logic stby_irq_d_r;
   logic stby_rise;
   logic kbd_irq_r;
   logic por_done;
   logic rail_ready;
   logic in_standby;
   logic other_irq;
   logic int_en_nxt;
   logic irq_nxt;

   if (RESTORE_CYC < 4) begin : g_bad_restore
      $error("standby_irq_combiner: RESTORE_CYC must be at least 4");
   end

   // ---------------------------------------------------------------
   // Input conditioning
   // ---------------------------------------------------------------
   key_debounce #(
      .STABLE_CYC (DEBOUNCE_CYC),
      .IDLE       (`SIC_IDLE_HIGH)
   ) u_key (
      .clk     (CLK),
      .rst     (RST),
      .raw     (STANDBY_KEY_N),
      .level_r (),
      .fall_r  (key_fall),
      .rise_r  ()
   );

   // Trigger is driven by logic, so no debounce; edge only, so a held
   // low level cannot re-enter standby right after a key wake-up
   always_ff @(posedge CLK) begin
      if (RST) begin
         trig_d_r <= 1'b1;
         kbd_d_r  <= 1'b0;
      end else begin
         trig_d_r <= STANDBY_TRIG_N;
         kbd_d_r  <= KBD_READY;
      end
   end

   assign trig_fall = trig_d_r & ~STANDBY_TRIG_N;
   assign kbd_rise  = KBD_READY & ~kbd_d_r;
   assign in_standby = (state_r == standby_irq_pkg::PWR_STANDBY);

   // ---------------------------------------------------------------
   // Standby interrupt latch
   // ---------------------------------------------------------------
   // Set wins over a clear in the same cycle
   always_ff @(posedge CLK) begin
      if (RST) begin
         stby_irq_r <= 1'b0;
      end else if (key_fall) begin
         stby_irq_r <= 1'b1;
      end else if (trig_fall && !in_standby) begin
         stby_irq_r <= 1'b1;
      end else if (STBY_LATCH_CLR) begin
         stby_irq_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         stby_irq_d_r <= 1'b0;
      end else begin
         stby_irq_d_r <= stby_irq_r;
      end
   end

   assign stby_rise = stby_irq_r & ~stby_irq_d_r;

   // ---------------------------------------------------------------
   // Standby state latch
   // ---------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      if (stby_rise) begin
         unique case (state_r)
            standby_irq_pkg::PWR_OPERATE: begin
               state_nxt = standby_irq_pkg::PWR_STANDBY;
            end
            standby_irq_pkg::PWR_STANDBY: begin
               state_nxt = standby_irq_pkg::PWR_OPERATE;
            end
            default: begin
               state_nxt = standby_irq_pkg::PWR_OPERATE;
            end
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         state_r <= standby_irq_pkg::PWR_OPERATE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         STANDBY_LED <= 1'b0;
         SHUTDOWN    <= 1'b0;
      end else begin
         STANDBY_LED <= in_standby;
         SHUTDOWN    <= in_standby;
      end
   end

   // ---------------------------------------------------------------
   // Keyboard interrupt latch
   // ---------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         kbd_irq_r <= 1'b0;
      end else if (kbd_rise) begin
         kbd_irq_r <= 1'b1;
      end else if (KBD_LATCH_CLR) begin
         kbd_irq_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Reset and restoration timing
   // ---------------------------------------------------------------
   hold_timer #(
      .CYCLES (POR_CYC)
   ) u_por (
      .clk    (CLK),
      .rst    (RST),
      .run    (1'b1),
      .done_r (por_done)
   );

   // Counts only while the main rail is up; a dip starts it over
   hold_timer #(
      .CYCLES (RESTORE_CYC)
   ) u_restore (
      .clk    (CLK),
      .rst    (RST),
      .run    (MAIN_RAIL_OK),
      .done_r (rail_ready)
   );

   assign int_en_nxt = por_done & rail_ready & MAIN_RAIL_OK;

   // ---------------------------------------------------------------
   // Interrupt combining
   // ---------------------------------------------------------------
   assign other_irq = kbd_irq_r | MEASUREMENT_IRQ |
                      BUS_INTERFACE_IRQ;
   assign irq_nxt = int_en_nxt &
                    (stby_irq_r |
                     (other_irq & ~in_standby));

   always_ff @(posedge CLK) begin
      if (RST) begin
         HOST_IRQ_N     <= `SIC_IDLE_HIGH;
         STBY_IRQ_FLAG  <= 1'b0;
         KBD_IRQ_FLAG   <= 1'b0;
         HOST_RESET_N   <= 1'b0;
         BUS_IF_RESET_N <= 1'b0;
      end else begin
         HOST_IRQ_N     <= ~irq_nxt;
         STBY_IRQ_FLAG  <= stby_irq_r;
         KBD_IRQ_FLAG   <= kbd_irq_r;
         HOST_RESET_N   <= por_done;
         BUS_IF_RESET_N <= int_en_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   sequence s_enter;
      !in_standby && stby_rise;
   endsequence

   sequence s_rail_back;
      $rose(MAIN_RAIL_OK) ##1 MAIN_RAIL_OK;
   endsequence

   property p_key_sets;
      key_fall |=> stby_irq_r ##1 STBY_IRQ_FLAG;
   endproperty
   a_key_sets: assert property (p_key_sets)
      else $error("Key press did not set standby flag");

   property p_stby_irq;
      stby_irq_r && int_en_nxt |=> !HOST_IRQ_N;
   endproperty
   a_stby_irq: assert property (p_stby_irq)
      else $error("Standby latch did not assert host interrupt");

   property p_enter;
      s_enter |=> in_standby ##1 (SHUTDOWN && STANDBY_LED);
   endproperty
   a_enter: assert property (p_enter)
      else $error("Standby not entered on flag edge");

   property p_block;
      in_standby && !stby_irq_r |=> HOST_IRQ_N;
   endproperty
   a_block: assert property (p_block)
      else $error("Other interrupt passed during standby");

   property p_clear;
      STBY_LATCH_CLR && !key_fall && !trig_fall && !stby_rise |=>
         !stby_irq_r && $stable(state_r);
   endproperty
   a_clear: assert property (p_clear)
      else $error("Latch clear failed or changed standby state");

   property p_leave;
      in_standby && stby_rise |=> !in_standby ##1 !SHUTDOWN;
   endproperty
   a_leave: assert property (p_leave)
      else $error("Standby not left on flag edge");

   property p_trig_no_wake;
      in_standby && trig_fall && !key_fall && !stby_irq_r |=> !stby_irq_r;
   endproperty
   a_trig_no_wake: assert property (p_trig_no_wake)
      else $error("Trigger woke the unit from standby");

   property p_kbd;
      kbd_rise |=> kbd_irq_r ##1 KBD_IRQ_FLAG;
   endproperty
   a_kbd: assert property (p_kbd)
      else $error("Keyboard ready did not set keyboard flag");

   property p_other;
      int_en_nxt && !in_standby && MEASUREMENT_IRQ |=> !HOST_IRQ_N;
   endproperty
   a_other: assert property (p_other)
      else $error("Measurement interrupt not forwarded");

   property p_rail_off;
      !MAIN_RAIL_OK |=> HOST_IRQ_N && !BUS_IF_RESET_N;
   endproperty
   a_rail_off: assert property (p_rail_off)
      else $error("Rail off did not mask interrupt and hold reset");

   property p_restore;
      s_rail_back |-> (!BUS_IF_RESET_N && HOST_IRQ_N) [*3];
   endproperty
   a_restore: assert property (p_restore)
      else $error("Interrupt enabled too soon after rail return");

   property p_por;
      !por_done |=> !HOST_RESET_N && !BUS_IF_RESET_N;
   endproperty
   a_por: assert property (p_por)
      else $error("Reset released before power-on hold ended");

   property p_flag;
      stby_irq_r |=> STBY_IRQ_FLAG;
   endproperty
   a_flag: assert property (p_flag)
      else $error("Standby flag does not follow the latch");

   property p_shutdown;
      in_standby |=> SHUTDOWN && STANDBY_LED;
   endproperty
   a_shutdown: assert property (p_shutdown)
      else $error("Rails not shut down in standby");

   property p_trig;
      trig_fall && !in_standby |=> stby_irq_r;
   endproperty
   a_trig: assert property (p_trig)
      else $error("Battery trigger did not request standby");

   property p_bus_irq;
      int_en_nxt && !in_standby && BUS_INTERFACE_IRQ |=> !HOST_IRQ_N;
   endproperty
   a_bus_irq: assert property (p_bus_irq)
      else $error("Bus interface interrupt not forwarded");

   property p_release;
      int_en_nxt && stby_irq_r |=> BUS_IF_RESET_N && !HOST_IRQ_N;
   endproperty
   a_release: assert property (p_release)
      else $error("Bus reset and interrupt enable not together");

endmodule // standby_irq_combiner
`default_nettype wire

//--- dv/host_model.sv
// Purpose: Host processor side, services the interrupt and clears latches
// Assumes: Flags read only while the interrupt line is low
// Notes:   LATENCY sets how slowly the interrupt routine answers
`timescale 1ns/10ps
`default_nettype none
module host_model #(
   parameter int unsigned LATENCY = 4
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic service_en,
   input  wire logic host_irq_n,
   input  wire logic stby_flag,
   input  wire logic kbd_flag,
   output var  logic stby_clr,
   output var  logic kbd_clr
);
   // ----------------------------------------
   // Interrupt routine
   // ----------------------------------------
   logic [7:0] wait_r;

   // Standby source first, keyboard only once standby is cleared
   always_ff @(posedge clk) begin
      stby_clr <= 1'h0;
      kbd_clr  <= 1'h0;
      if (rst || !service_en || host_irq_n) begin
         wait_r <= 8'h00;
      end else if (wait_r == LATENCY[7:0]) begin
         wait_r   <= 8'h00;
         stby_clr <= stby_flag;
         kbd_clr  <= kbd_flag && !stby_flag;
      end else begin
         wait_r <= wait_r + 8'h01;
      end
   end
endmodule // host_model
`default_nettype wire

//--- dv/test_standby_irq_combiner.sv
// Purpose: Directed bench for the standby and interrupt combiner
// Assumes: Short counts for power-on, debounce and restore delay
// Notes:   Inputs driven by NBA at the rising edge, sampled 1 ns later
`timescale 1ns/10ps
`default_nettype none
module test_standby_irq_combiner;
   localparam int unsigned POR  = 20;
   localparam int unsigned DEB  = 3;
   localparam int unsigned REST = 8;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic key_n = 1'h1;
   logic trig_n = 1'h1;
   logic kbd_rdy = 1'h0;
   logic meas_irq = 1'h0;
   logic bus_irq = 1'h0;
   logic rail_ok = 1'h1;
   logic svc_en = 1'h0;
   logic stby_clr, kbd_clr, irq_n, stby_flag, kbd_flag;
   logic led, shutdown, host_rst_n, bus_rst_n;
   int   mismatches = 0;
   int   num_checks = 0;
   int   cycles = 0;
   int   n;

   always #5 clk = ~clk;

   standby_irq_combiner #(.POR_CYC(POR), .DEBOUNCE_CYC(DEB),
                          .RESTORE_CYC(REST)) dut (
      .CLK(clk), .RST(rst), .STANDBY_KEY_N(key_n), .STANDBY_TRIG_N(trig_n),
      .KBD_READY(kbd_rdy), .MEASUREMENT_IRQ(meas_irq),
      .BUS_INTERFACE_IRQ(bus_irq), .MAIN_RAIL_OK(rail_ok),
      .STBY_LATCH_CLR(stby_clr), .KBD_LATCH_CLR(kbd_clr),
      .HOST_IRQ_N(irq_n), .STBY_IRQ_FLAG(stby_flag),
      .KBD_IRQ_FLAG(kbd_flag), .STANDBY_LED(led), .SHUTDOWN(shutdown),
      .HOST_RESET_N(host_rst_n), .BUS_IF_RESET_N(bus_rst_n));

   host_model #(.LATENCY(4)) host (
      .clk(clk), .rst(rst), .service_en(svc_en), .host_irq_n(irq_n),
      .stby_flag(stby_flag), .kbd_flag(kbd_flag),
      .stby_clr(stby_clr), .kbd_clr(kbd_clr));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic final_report();
      if (mismatches == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic seen, input logic exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
      end
   endtask

   task automatic wait_cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   // Key held low for len cycles, then released and debounced
   task automatic press(input int len);
      @(posedge clk);
      key_n <= 1'h0;
      repeat (len) @(posedge clk);
      key_n <= 1'h1;
      wait_cyc(12);
   endtask

   // Long enough for the host to clear both latches in turn
   task automatic service();
      @(posedge clk);
      svc_en <= 1'h1;
      repeat (24) @(posedge clk);
      svc_en <= 1'h0;
      wait_cyc(4);
   endtask

   // Hang guard, whole run is a few hundred cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         final_report();
      end
   end

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      wait_cyc(15);
      chk("irq_n", irq_n, 1'h1);
      chk("stby_flag", stby_flag, 1'h0);
      chk("kbd_flag", kbd_flag, 1'h0);
      chk("led", led, 1'h0);
      chk("shutdown", shutdown, 1'h0);
      chk("host_rst_n", host_rst_n, 1'h0);
      chk("bus_rst_n", bus_rst_n, 1'h0);
      @(posedge clk);
      rst <= 1'h0;
      wait_cyc(10);
      chk("host_rst_n", host_rst_n, 1'h0);
      wait_cyc(25);
      chk("host_rst_n", host_rst_n, 1'h1);
      chk("bus_rst_n", bus_rst_n, 1'h1);
      @(posedge clk);
      kbd_rdy <= 1'h1;
      wait_cyc(4);
      chk("kbd_flag", kbd_flag, 1'h1);
      chk("irq_n", irq_n, 1'h0);
      @(posedge clk);
      kbd_rdy <= 1'h0;
      service();
      chk("kbd_flag", kbd_flag, 1'h0);
      chk("irq_n", irq_n, 1'h1);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         meas_irq <= (i == 0);
         bus_irq  <= (i == 1);
         wait_cyc(3);
         chk("irq_n", irq_n, 1'h0);
         @(posedge clk);
         meas_irq <= 1'h0;
         bus_irq  <= 1'h0;
         wait_cyc(3);
         chk("irq_n", irq_n, 1'h1);
      end
      press(1);
      chk("stby_flag", stby_flag, 1'h0);
      press(10);
      chk("stby_flag", stby_flag, 1'h1);
      chk("irq_n", irq_n, 1'h0);
      chk("led", led, 1'h1);
      chk("shutdown", shutdown, 1'h1);
      service();
      chk("stby_flag", stby_flag, 1'h0);
      chk("led", led, 1'h1);
      @(posedge clk);
      meas_irq <= 1'h1;
      kbd_rdy  <= 1'h1;
      wait_cyc(4);
      chk("irq_n", irq_n, 1'h1);
      chk("kbd_flag", kbd_flag, 1'h1);
      @(posedge clk);
      rail_ok  <= 1'h0;
      meas_irq <= 1'h0;
      kbd_rdy  <= 1'h0;
      wait_cyc(3);
      chk("bus_rst_n", bus_rst_n, 1'h0);
      chk("irq_n", irq_n, 1'h1);
      press(10);
      chk("stby_flag", stby_flag, 1'h1);
      chk("irq_n", irq_n, 1'h1);
      chk("led", led, 1'h0);
      chk("shutdown", shutdown, 1'h0);
      @(posedge clk);
      rail_ok <= 1'h1;
      wait_cyc(5);
      chk("irq_n", irq_n, 1'h1);
      n = 5;
      while (bus_rst_n !== 1'h1 && n < 40) begin
         chk("irq_n", irq_n, 1'h1);
         wait_cyc(1);
         n++;
      end
      chk("restore delay", n == REST + 1, 1'h1);
      chk("irq_n", irq_n, 1'h0);
      service();
      chk("stby_flag", stby_flag, 1'h0);
      chk("kbd_flag", kbd_flag, 1'h0);
      @(posedge clk);
      trig_n <= 1'h0;
      wait_cyc(6);
      chk("stby_flag", stby_flag, 1'h1);
      chk("led", led, 1'h1);
      service();
      @(posedge clk);
      trig_n <= 1'h1;
      @(posedge clk);
      trig_n <= 1'h0;
      wait_cyc(6);
      chk("stby_flag", stby_flag, 1'h0);
      chk("led", led, 1'h1);
      press(10);
      chk("led", led, 1'h0);
      chk("shutdown", shutdown, 1'h0);
      service();
      chk("led", led, 1'h0);
      // Second reset in mid-run; trigger idles so no false edge follows
      @(posedge clk);
      rst    <= 1'h1;
      trig_n <= 1'h1;
      wait_cyc(3);
      chk("host_rst_n", host_rst_n, 1'h0);
      chk("bus_rst_n", bus_rst_n, 1'h0);
      chk("irq_n", irq_n, 1'h1);
      @(posedge clk);
      rst <= 1'h0;
      wait_cyc(2);
      chk("host_rst_n", host_rst_n, 1'h0);
      wait_cyc(POR);
      chk("host_rst_n", host_rst_n, 1'h1);
      final_report();
   end
endmodule // test_standby_irq_combiner
`default_nettype wire
